// ---- design/ext_interrupt_sense_control.sv ----
// Sense control register, pin detection and masking for external requests.
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1 - 16-bit register, resets 0x4000, survives standby
// R2 - Bit 15 masks all while NMI low
// R3 - Bit 15 also masks NMI in standby
// R4 - Bit 14 selects independent or encoded pins
// R5 - Bit 13 clear masks NMI when block set
// R6 - Bit 12 enables alternate encoded pins
// R7 - Bits 11:10 sense mode of pin 5
// R8 - Bits 9:8 sense mode of pin 4
// R9 - Bits 7:6 sense mode of pin 3
// R10 - Bits 5:4 sense mode of pin 2
// R11 - Bits 3:2 sense mode of pin 1
// R12 - Bits 1:0 sense mode of pin 0
// R13 - Effective level is higher encoded input
// R14 - Edge request pending until flag cleared
// R15 - Software never writes reserved sense code
module ext_interrupt_sense_control (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Request pins, active low
  input  wire logic [5:0]  extRequestPinN,
  input  wire logic [3:0]  alternateEncodedLevelN,
  // CPU and system state
  input  wire logic        nmiPinLevel,
  input  wire logic        nmiRequest,
  input  wire logic        cpuBlockBit,
  input  wire logic        standbyMode,
  // Results
  output logic [5:0]       pinRequest,
  output logic [3:0]       encodedLevel,
  output logic             maskAllActive,
  output logic             nmiAccepted
);
  import ext_sense_pkg::*;

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [15:0] senseCtrl_r;
  logic [15:0] senseCtrl_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        err_r;
  logic        err_nxt;
  logic [5:0]  clearReq;
  logic [5:0]  rawReq;
  logic        access;
  logic        hitCtrl;
  logic        hitFlag;

  function automatic logic [1:0] pin_mode(input logic [15:0] r,
                                          input int pin);
    pin_mode = r[2*pin +: 2];
  endfunction : pin_mode

  assign access  = psel & penable;
  assign hitCtrl = (paddr == SENSE_CTRL_OFFSET);
  assign hitFlag = (paddr == FLAG_OFFSET);

  always_comb begin
    senseCtrl_nxt = senseCtrl_r;
    rdata_nxt     = rdata_r;
    err_nxt       = 1'b0;
    clearReq      = 6'h00;
    if (psel && !penable) begin
      // Setup cycle: decode and prepare the answer.
      if (hitCtrl) begin
        rdata_nxt = {16'h0000, senseCtrl_r};
      end else if (hitFlag) begin
        rdata_nxt = {26'h0000000, pinRequest};
      end else begin
        rdata_nxt = 32'h00000000;
        err_nxt   = 1'b1;
      end
    end else if (access) begin
      err_nxt = err_r;
      if (pwrite && hitCtrl) begin
        // R1 software load
        senseCtrl_nxt = pwdata[15:0];
      end else if (pwrite && hitFlag) begin
        // R14 zero clears flag
        clearReq = ~pwdata[5:0];
      end
    end
  end

  // R1 reset value; standby does not touch the register.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      senseCtrl_r <= SENSE_CTRL_RESET;
      rdata_r     <= 32'h00000000;
      err_r       <= 1'b0;
    end else begin
      senseCtrl_r <= senseCtrl_nxt;
      rdata_r     <= rdata_nxt;
      err_r       <= err_nxt;
    end
  end

  assign pready  = access;
  assign prdata  = rdata_r;
  assign pslverr = access & err_r;

  // ---------------------------------------------------------------
  // Pin sensing
  // ---------------------------------------------------------------
  logic encSel;
  logic altEn;

  assign encSel = senseCtrl_r[ENC_SEL_BIT];
  // R6 valid only when encoded
  assign altEn  = senseCtrl_r[SECOND_EN_BIT] & encSel;

  // R7 R8 R9 R10 R11 R12 per-pin sense fields
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    pin_sense_unit u_sense (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .senseMode (pin_mode(senseCtrl_r, i)),
      .clearFlag (clearReq[i]),
      .pinLevel  (extRequestPinN[i]),
      .request   (rawReq[i])
    );
  end

  logic [3:0] mergedLvl;

  level_merge u_merge (
    .primaryLevelN   (extRequestPinN[NUM_ENC_PINS-1:0]),
    .alternateLevelN (alternateEncodedLevelN),
    .alternateOn     (altEn),
    .mergedLevel     (mergedLvl)
  );

  // ---------------------------------------------------------------
  // Masking
  // ---------------------------------------------------------------
  logic maskAll;
  logic nmiOk;

  always_comb begin
    // R2 mask all on NMI low
    maskAll = senseCtrl_r[MASK_ALL_BIT] & ~nmiPinLevel;
    // R3 R5 NMI gating
    nmiOk = nmiRequest
          & ~(senseCtrl_r[MASK_ALL_BIT] & standbyMode)
          & ~(~senseCtrl_r[BLOCK_OVR_BIT] & cpuBlockBit)
          & ~maskAll;
  end

  logic [5:0] pinReq_r;
  logic [3:0] level_r;
  logic       maskAll_r;
  logic       nmiOk_r;
  logic [5:0] pinReq_nxt;
  logic [3:0] level_nxt;

  always_comb begin
    pinReq_nxt = maskAll ? 6'h00 : rawReq;
    level_nxt  = 4'h0;
    // R4 encoded or independent
    if (encSel) begin
      pinReq_nxt[NUM_ENC_PINS-1:0] = 4'h0;
      level_nxt = maskAll ? 4'h0 : mergedLvl;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pinReq_r  <= 6'h00;
      level_r   <= 4'h0;
      maskAll_r <= 1'b0;
      nmiOk_r   <= 1'b0;
    end else begin
      pinReq_r  <= pinReq_nxt;
      level_r   <= level_nxt;
      maskAll_r <= maskAll;
      nmiOk_r   <= nmiOk;
    end
  end

  assign pinRequest    = pinReq_r;
  assign encodedLevel  = level_r;
  assign maskAllActive = maskAll_r;
  assign nmiAccepted   = nmiOk_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_ctrl_write;
    psel && penable && pwrite && hitCtrl;
  endsequence

  property p_write_lands;
    @(posedge ref_clk) disable iff (rst)
      s_ctrl_write |=> senseCtrl_r == $past(pwdata[15:0]);
  endproperty
  a_write_lands: assert property (p_write_lands) // R1
    else $error("control write not stored");

  property p_standby_keeps;
    @(posedge ref_clk) disable iff (rst)
      (standbyMode && !(psel && penable && pwrite))
      |=> $stable(senseCtrl_r);
  endproperty
  a_standby_keeps: assert property (p_standby_keeps) // R1
    else $error("control changed in standby");

  property p_mask_all;
    @(posedge ref_clk) disable iff (rst)
      (senseCtrl_r[MASK_ALL_BIT] && !nmiPinLevel)
      |=> pinRequest == 6'h00 && encodedLevel == 4'h0;
  endproperty
  a_mask_all: assert property (p_mask_all) // R2
    else $error("request passed while NMI low and mask set");

  property p_standby_nmi;
    @(posedge ref_clk) disable iff (rst)
      (senseCtrl_r[MASK_ALL_BIT] && standbyMode) |=> !nmiAccepted;
  endproperty
  a_standby_nmi: assert property (p_standby_nmi) // R3
    else $error("NMI accepted in standby");

  property p_encoded;
    @(posedge ref_clk) disable iff (rst)
      encSel |=> pinRequest[3:0] == 4'h0;
  endproperty
  a_encoded: assert property (p_encoded) // R4
    else $error("independent requests while encoded");

  property p_block;
    @(posedge ref_clk) disable iff (rst)
      (!senseCtrl_r[BLOCK_OVR_BIT] && cpuBlockBit) |=> !nmiAccepted;
  endproperty
  a_block: assert property (p_block) // R5
    else $error("NMI accepted under block bit");

  property p_alt_off;
    @(posedge ref_clk) disable iff (rst)
      (encSel && !senseCtrl_r[SECOND_EN_BIT] && !maskAll)
      |=> encodedLevel == ~$past(extRequestPinN[3:0]);
  endproperty
  a_alt_off: assert property (p_alt_off) // R6
    else $error("alternate pins used while disabled");

  property p_low_level;
    @(posedge ref_clk) disable iff (rst)
      (pin_mode(senseCtrl_r, 5) == SENSE_LOW && !maskAll)
      |=> pinRequest[5] == ~$past(extRequestPinN[5]);
  endproperty
  a_low_level: assert property (p_low_level) // R7
    else $error("pin 5 low level not followed");

  property p_low_pin2;
    @(posedge ref_clk) disable iff (rst)
      (pin_mode(senseCtrl_r, 2) == SENSE_LOW && !encSel && !maskAll)
      |=> pinRequest[2] == ~$past(extRequestPinN[2]);
  endproperty
  a_low_pin2: assert property (p_low_pin2) // R10
    else $error("pin 2 low level not followed");

  property p_indep_level;
    @(posedge ref_clk) disable iff (rst)
      !encSel |=> encodedLevel == 4'h0;
  endproperty
  a_indep_level: assert property (p_indep_level) // R4
    else $error("encoded level shown in independent mode");

  property p_alt_wins;
    @(posedge ref_clk) disable iff (rst)
      (altEn && !maskAll
       && ((~alternateEncodedLevelN) > (~extRequestPinN[3:0])))
      |=> encodedLevel == ~$past(alternateEncodedLevelN);
  endproperty
  a_alt_wins: assert property (p_alt_wins) // R13
    else $error("higher alternate level not chosen");

  // Pin 4 stands for every rising-edge pin; they share one unit design.
  property p_rise_pin4;
    @(posedge ref_clk) disable iff (rst)
      (pin_mode(senseCtrl_r, 4) == SENSE_RISE
       && !g_pin[4].u_sense.pinPrev_r && extRequestPinN[4])
      |=> rawReq[4] || pin_mode(senseCtrl_r, 4) == SENSE_LOW;
  endproperty
  a_rise_pin4: assert property (p_rise_pin4) // R8
    else $error("pin 4 rising edge not latched");

  sequence s_clear_pin0;
    psel && penable && pwrite && hitFlag && !pwdata[0]
    && !g_pin[0].u_sense.edgeSeen
    && pin_mode(senseCtrl_r, 0) != SENSE_LOW;
  endsequence

  // A clear with no new edge in the same cycle must drop the request.
  property p_clear_pin0;
    @(posedge ref_clk) disable iff (rst)
      s_clear_pin0
      |=> !rawReq[0] || pin_mode(senseCtrl_r, 0) == SENSE_LOW;
  endproperty
  a_clear_pin0: assert property (p_clear_pin0) // R14
    else $error("cleared pin 0 request still pending");
endmodule : ext_interrupt_sense_control
`default_nettype wire

// ---- design/ext_sense_pkg.sv ----
// Package of register map, field positions and codes for external sensing.
package ext_sense_pkg;
  localparam logic [11:0] SENSE_CTRL_OFFSET = 12'h000;
  localparam logic [11:0] FLAG_OFFSET       = 12'h004;
  localparam logic [15:0] SENSE_CTRL_RESET  = 16'h4000;
  localparam int          MASK_ALL_BIT      = 15;
  localparam int          ENC_SEL_BIT       = 14;
  localparam int          BLOCK_OVR_BIT     = 13;
  localparam int          SECOND_EN_BIT     = 12;
  localparam int          NUM_PINS          = 6;
  localparam int          NUM_ENC_PINS      = 4;
  localparam logic [1:0]  SENSE_FALL        = 2'h0;
  localparam logic [1:0]  SENSE_RISE        = 2'h1;
  localparam logic [1:0]  SENSE_LOW         = 2'h2;
  localparam logic [5:0]  FLAG_RESET        = 6'h00;
endpackage : ext_sense_pkg

// ---- design/pin_sense_unit.sv ----
// One pin's sense logic: edge capture into a sticky flag or low-level pass.
`timescale 1ns/1ps
`default_nettype none
module pin_sense_unit (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Control
  input  wire logic [1:0] senseMode,
  input  wire logic       clearFlag,
  // Pin and result
  input  wire logic       pinLevel,
  output logic            request
);
  import ext_sense_pkg::*;

  logic pinPrev_r;
  logic pinPrev_nxt;
  logic flag_r;
  logic flag_nxt;
  logic edgeSeen;

  always_comb begin
    pinPrev_nxt = pinLevel;
    case (senseMode)
      SENSE_FALL: edgeSeen = pinPrev_r & ~pinLevel;
      SENSE_RISE: edgeSeen = ~pinPrev_r & pinLevel;
      default:    edgeSeen = 1'b0;
    endcase
    // A new edge wins over a clear in the same cycle.
    if (edgeSeen) begin
      flag_nxt = 1'b1;
    end else if (clearFlag || senseMode == SENSE_LOW) begin
      flag_nxt = 1'b0;
    end else begin
      flag_nxt = flag_r;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pinPrev_r <= 1'b1;
      flag_r    <= 1'b0;
    end else begin
      pinPrev_r <= pinPrev_nxt;
      flag_r    <= flag_nxt;
    end
  end

  // Low level is a live condition; reserved code sets no new flag but passes on a held one.
  assign request = (senseMode == SENSE_LOW) ? ~pinLevel : flag_r;

  property p_edge_sets;
    @(posedge ref_clk) disable iff (rst)
      (senseMode == SENSE_FALL && pinPrev_r && !pinLevel)
      |=> flag_r;
  endproperty
  a_edge_sets: assert property (p_edge_sets) // R14
    else $error("falling edge did not set the flag");

  property p_flag_holds;
    @(posedge ref_clk) disable iff (rst)
      (flag_r && !clearFlag && senseMode != SENSE_LOW
       && $stable(senseMode)) |=> flag_r;
  endproperty
  a_flag_holds: assert property (p_flag_holds) // R14
    else $error("pending flag dropped without a clear");
endmodule : pin_sense_unit
`default_nettype wire

// ---- design/level_merge.sv ----
// Merges the two encoded level inputs, picking the higher active level.
`timescale 1ns/1ps
`default_nettype none
module level_merge (
  // Encoded inputs, active low as on the pins
  input  wire logic [3:0] primaryLevelN,
  input  wire logic [3:0] alternateLevelN,
  input  wire logic       alternateOn,
  // Resulting level, 0 means none
  output logic [3:0]      mergedLevel
);
  logic [3:0] primLvl;
  logic [3:0] altLvl;

  always_comb begin
    primLvl = ~primaryLevelN;
    altLvl  = alternateOn ? ~alternateLevelN : 4'h0;
    // R13 higher level wins
    mergedLevel = (altLvl > primLvl) ? altLvl : primLvl;
  end
endmodule : level_merge
`default_nettype wire

// ---- verif/pin_source_model.sv ----
// Model of the request sources that drive the external pins.
`timescale 1ns/1ps
`default_nettype none
module pin_source_model (
  // Clock
  input  wire logic       ref_clk,
  // Wanted levels, active low
  input  wire logic [5:0] wantPinN,
  input  wire logic [3:0] wantAltN,
  // Pins
  output logic [5:0]      extRequestPinN,
  output logic [3:0]      alternateEncodedLevelN
);
  // Pins follow the wanted levels one edge later, like a clocked source.
  // A single process drives them, so the idle level comes from the bench.
  always @(posedge ref_clk) begin
    extRequestPinN <= wantPinN;
    alternateEncodedLevelN <= wantAltN;
  end
endmodule : pin_source_model
`default_nettype wire

// ---- verif/test_ext_interrupt_sense_control.sv ----
// Testbench of the external request sense control block.
`timescale 1ns/1ps
`default_nettype none
module test_ext_interrupt_sense_control;
  import ext_sense_pkg::*;
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [5:0]  pinN, wantPinN, pinRequest;
  logic [3:0]  altN, wantAltN, encodedLevel;
  logic        nmiPinLevel, nmiRequest, cpuBlockBit, standbyMode;
  logic        maskAllActive, nmiAccepted;
  logic [15:0] cv;
  logic [15:0] ctl [4] = '{16'h0000, 16'h8000, 16'h2000, 16'hA000};
  int          err_count, comparisons;

  ext_interrupt_sense_control uut (.ref_clk(ref_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .extRequestPinN(pinN), .alternateEncodedLevelN(altN),
    .nmiPinLevel(nmiPinLevel), .nmiRequest(nmiRequest),
    .cpuBlockBit(cpuBlockBit), .standbyMode(standbyMode),
    .pinRequest(pinRequest), .encodedLevel(encodedLevel),
    .maskAllActive(maskAllActive), .nmiAccepted(nmiAccepted));
  pin_source_model src (.ref_clk(ref_clk), .wantPinN(wantPinN),
    .wantAltN(wantAltN), .extRequestPinN(pinN),
    .alternateEncodedLevelN(altN));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task test_done;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask : chk

  task wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wt

  // One APB transfer; an idle cycle follows so requests never collide.
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_count++;
      test_done();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : bus

  initial begin
    {rst, psel, penable, pwrite} = 4'b1000;
    paddr = 12'h000;
    pwdata = 32'h0;
    {wantPinN, wantAltN} = 10'h3FF;
    {nmiPinLevel, nmiRequest, cpuBlockBit, standbyMode} = 4'b1000;
    err_count = 0;
    comparisons = 0;
    wt(20);
    rst <= 1'b0;
    wt(1);
    bus(0, SENSE_CTRL_OFFSET, 0);
    chk("ctrl", 32'h4000, q);
    bus(0, FLAG_OFFSET, 0);
    chk("flags", 32'h0, q);
    bus(1, SENSE_CTRL_OFFSET, 32'h8924);
    bus(0, SENSE_CTRL_OFFSET, 0);
    chk("ctrl", 32'h8924, q);
    bus(0, 12'h008, 0);
    chk("unmapped", 32'h1, {q[30:0], e});
    wantPinN <= 6'b010010;
    wt(4);
    chk("req", 6'b101101, pinRequest);
    wantPinN <= 6'h3F;
    wt(4);
    chk("req", 6'b001001, pinRequest);
    wantPinN <= 6'b101101;
    wt(4);
    wantPinN <= 6'h3F;
    wt(4);
    chk("req", 6'b011011, pinRequest);
    bus(0, FLAG_OFFSET, 0);
    chk("flags", 32'h1B, q);
    bus(1, FLAG_OFFSET, 32'h3C);
    wt(2);
    chk("req", 6'b011000, pinRequest);
    wantPinN <= 6'h3C;
    wantAltN <= 4'h6;
    bus(1, SENSE_CTRL_OFFSET, 32'h4000);
    wt(3);
    chk("level", 32'h3, encodedLevel);
    chk("req", 32'h0, pinRequest[3:0]);
    bus(1, SENSE_CTRL_OFFSET, 32'h5000);
    wt(3);
    chk("level", 32'h9, encodedLevel);
    wantAltN <= 4'hE;
    wt(3);
    chk("level", 32'h3, encodedLevel);
    bus(1, SENSE_CTRL_OFFSET, 32'h1000);
    wt(3);
    chk("level", 32'h0, encodedLevel);
    nmiRequest <= 1'b1;
    for (int k = 0; k < 32; k++) begin
      cv = ctl[k/8];
      if (k % 8 == 0) bus(1, SENSE_CTRL_OFFSET, {16'h0, cv});
      {nmiPinLevel, cpuBlockBit, standbyMode} <= k[2:0];
      wt(3);
      chk("mask", cv[15] && !nmiPinLevel, maskAllActive);
      chk("nmi", !(cpuBlockBit && !cv[13]) && !(standbyMode && cv[15])
        && !(cv[15] && !nmiPinLevel), nmiAccepted);
    end
    bus(0, SENSE_CTRL_OFFSET, 0);
    chk("ctrl", 32'hA000, q);
    rst <= 1'b1;
    wt(2);
    rst <= 1'b0;
    wt(1);
    bus(0, SENSE_CTRL_OFFSET, 0);
    chk("ctrl", 32'h4000, q);
    test_done();
  end
endmodule : test_ext_interrupt_sense_control
`default_nettype wire
